// >>> analog_model.sv
// behavioural analog converter answering the control block's conversion starts
`timescale 1ns/1ps
module analog_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // converter side
  input wire logic convStart,
  input wire logic sarTick,
  input wire logic byteModeSel,
  input wire logic [9:0] sample,
  output logic resultValid,
  output logic [9:0] resultData
);
  int left;
  logic [9:0] last;
  // counts sar clocks of one conversion: 11 for 8-bit, 13 for 10-bit
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      left <= 0;
      resultValid <= 1'b0;
      last <= 10'h000;
    end else begin
      resultValid <= 1'b0;
      if (convStart) begin
        left <= byteModeSel ? 11 : 13;
      end else if (left > 0 && sarTick) begin
        left <= left - 1;
        if (left == 1) begin
          resultValid <= 1'b1;
          last <= sample;
        end
      end
    end
  end
  // data is only held with the valid pulse, inverted otherwise
  assign resultData = resultValid ? last : ~last;
endmodule // analog_model

// >>> sar_adc_ctrl.sv
// converter control: register pair, start selection, sequencing and flags
// Function
// - enable at 0 keeps the converter powered down except while a burst runs, at 1 it is powered and may convert.
// - burst select picks single or burst operation, changing flag meaning and clock source.
// - the done flag sets after each single conversion or each whole burst; software clears it.
// - writing 1 to busy starts a conversion only when the start source field is 000.
// - the window flag sets when the result lies inside the threshold window; software clears it.
// - source field: 000 software, 001/010/011 timer 0/2/3 overflow, 1xx start pin rising edge.
// - the sar clock is the source clock divided by divider field plus one.
// - the divider source is the system clock without burst and the oscillator with burst.
// - byte mode at 0 gives 10-bit conversions and at 1 gives 8-bit conversions.
// - delayed tracking adds 3 sar clocks of tracking after the start before converting.
// - the gain bit gives gain 0.5 when clear and 1 when set.
// - in byte mode the two lowest result bits are zero and the low byte reads 0x00.
// - burst with enable at 0 powers down after a burst and waits (field+1) x 400 ns.
`timescale 1ns/1ps
module sar_adc_ctrl import sar_adc_pkg::*; #(
  parameter int DIV_W = 5,
  parameter int BURST_W = 7
) (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // special function register bus
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrEn,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrRdEn,
  output logic [7:0] sfrRdData,
  // start sources and oscillator
  input wire logic timer0Ovf,
  input wire logic timer2Ovf,
  input wire logic timer3Ovf,
  input wire logic extStartPin,
  input wire logic lpoTick,
  // settings held by neighbouring registers
  input wire logic [3:0] powerupDelayField,
  input wire logic [BURST_W-1:0] burstConvs,
  input wire logic [15:0] windowGreater,
  input wire logic [15:0] windowLess,
  // analog converter
  output logic convPowerOn,
  output logic inputGainOne,
  output logic byteModeSel,
  output logic tracking,
  output logic sarTick,
  output logic convStart,
  input wire logic resultValid,
  input wire logic [9:0] resultData,
  // results and flags
  output logic [7:0] resultHigh,
  output logic [7:0] resultLow,
  output logic doneIrq,
  output logic windowIrq
);
  generate
    if (DIV_W != CFG_DIV_MSB - CFG_DIV_LSB + 1 || BURST_W < 1) begin : g_badParam
      $error("sar_adc_ctrl: unsupported parameter values");
    end
  endgenerate

  logic enable_r, burst_r, done_r, win_r, pinPrev_r, convStart_r;
  logic [2:0] srcSel_r;
  logic [7:0] config_r, rdData_r, resHigh_r, resLow_r;
  logic [BURST_W-1:0] convsLeft_r;
  logic [8:0] cnt_r;
  seq_state_t state_r, state_nxt;

  sar_clk_if #(.DIV_W(DIV_W)) clkIf ();

  // ***************************************************
  // register access decode
  // ***************************************************
  wire wrCtl = ce && sfrWrEn && (sfrAddr == ADDR_CONTROL);
  wire wrCfg = ce && sfrWrEn && (sfrAddr == ADDR_CONFIG);
  wire busy = (state_r != ST_IDLE);
  wire [7:0] ctlView = {enable_r, burst_r, done_r, busy, win_r, srcSel_r};
  wire [7:0] rdMux = (sfrAddr == ADDR_CONTROL) ? ctlView :
                     (sfrAddr == ADDR_CONFIG) ? config_r : UNMAPPED_READ;
  wire byteMode = config_r[CFG_BYTE];
  wire delayed = config_r[CFG_TRACK];

  // ***************************************************
  // start selection
  // ***************************************************
  wire pinRise = extStartPin && !pinPrev_r;
  wire softStart = wrCtl && sfrWrData[CTL_BUSY]
                   && (sfrWrData[CTL_SRC_MSB:CTL_SRC_LSB] == SRC_SOFT);
  wire hwStart = srcSel_r[SRC_PIN_BIT] ? pinRise :
                 (srcSel_r == SRC_TMR0) ? timer0Ovf :
                 (srcSel_r == SRC_TMR2) ? timer2Ovf :
                 (srcSel_r == SRC_TMR3) ? timer3Ovf : 1'b0;
  // starts landing mid-sequence are dropped; the starter keeps the spacing
  wire accept = ce && (softStart || hwStart) && !busy && (enable_r || burst_r);
  wire needPowerup = burst_r && !enable_r;
  wire capture = ce && (state_r == ST_CONVERT) && resultValid;
  wire lastConv = !burst_r || (convsLeft_r <= 1);
  wire [9:0] capValue = byteMode ? {resultData[9:2], BYTE_MODE_LSBS} : resultData;
  wire [15:0] capWide = {6'h00, capValue};
  wire inWindow = (capWide > windowGreater) && (capWide < windowLess);
  wire doneSet = capture && lastConv;
  wire winSet = capture && inWindow;
  wire [8:0] powerupCyc = 9'((powerupDelayField + 5'h01) * POWERUP_UNIT_CYC);
  wire convPhase = (state_r == ST_TRACK) || (state_r == ST_CONVERT);

  // ***************************************************
  // sequencer next state
  // ***************************************************
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (accept) state_nxt = needPowerup ? ST_POWERUP : (delayed ? ST_TRACK : ST_CONVERT);
      end
      ST_POWERUP: begin
        if (cnt_r <= 9'h001) state_nxt = delayed ? ST_TRACK : ST_CONVERT;
      end
      ST_TRACK: begin
        if (sarTick && cnt_r <= 9'h001) state_nxt = ST_CONVERT;
      end
      ST_CONVERT: begin
        if (capture) state_nxt = lastConv ? ST_IDLE : (delayed ? ST_TRACK : ST_CONVERT);
      end
      default: state_nxt = ST_IDLE;
    endcase
  end
  wire enterConv = ce && (state_nxt == ST_CONVERT) && ((state_r != ST_CONVERT) || capture);
  wire enterTrack = (state_nxt == ST_TRACK) && ((state_r != ST_TRACK) || capture);

  // ***************************************************
  // outputs
  // ***************************************************
  assign clkIf.divValue = config_r[CFG_DIV_MSB:CFG_DIV_LSB];
  assign clkIf.lpoSelect = burst_r;
  assign clkIf.lpoTick = lpoTick;
  assign clkIf.run = convPhase;
  assign sarTick = clkIf.sarTick;
  assign convPowerOn = enable_r || (burst_r && busy);
  assign inputGainOne = config_r[CFG_GAIN];
  assign byteModeSel = byteMode;
  assign tracking = (state_r == ST_TRACK);
  assign convStart = convStart_r;
  assign sfrRdData = rdData_r;
  assign resultHigh = resHigh_r;
  assign resultLow = resLow_r;
  assign doneIrq = done_r;
  assign windowIrq = win_r;

  sar_clk_div #(.DIV_W(DIV_W)) u_div (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .clkIf(clkIf)
  );

  // software writes and sticky flags; a hardware set beats a clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      {enable_r, burst_r, done_r} <= CONTROL_RESET[CTL_ENABLE:CTL_DONE];
      win_r <= CONTROL_RESET[CTL_WIN];
      srcSel_r <= CONTROL_RESET[CTL_SRC_MSB:CTL_SRC_LSB];
      config_r <= CONFIG_RESET;
    end else if (ce) begin
      if (wrCtl) {enable_r, burst_r} <= sfrWrData[CTL_ENABLE:CTL_BURST];
      if (wrCtl) srcSel_r <= sfrWrData[CTL_SRC_MSB:CTL_SRC_LSB];
      if (wrCfg) config_r <= sfrWrData;
      done_r <= doneSet || (wrCtl ? sfrWrData[CTL_DONE] : done_r);
      win_r <= winSet || (wrCtl ? sfrWrData[CTL_WIN] : win_r);
    end
  end

  // read data and result capture
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdData_r <= 8'h00;
      resHigh_r <= 8'h00;
      resLow_r <= 8'h00;
      pinPrev_r <= 1'b0;
      convStart_r <= 1'b0;
    end else if (ce) begin
      if (sfrRdEn) rdData_r <= rdMux;
      if (capture) resHigh_r <= byteMode ? capValue[9:2] : {6'h00, capValue[9:8]};
      if (capture) resLow_r <= byteMode ? BYTE_MODE_LOW : capValue[7:0];
      pinPrev_r <= extStartPin;
      convStart_r <= enterConv;
    end
  end

  // sequencer state, delay count and burst count
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
      convsLeft_r <= '0;
    end else if (ce) begin
      state_r <= state_nxt;
      if (accept) convsLeft_r <= burst_r ? burstConvs : BURST_W'(1);
      else if (capture) convsLeft_r <= convsLeft_r - 1'b1;
      if (accept && needPowerup) cnt_r <= powerupCyc;
      else if (enterTrack) cnt_r <= 9'(DELAY_TRACK_SARCLK);
      else if ((state_r == ST_POWERUP) || (state_r == ST_TRACK && sarTick)) cnt_r <= cnt_r - 1'b1;
    end
  end

  // ***************************************************
  // checks
  // ***************************************************
  logic [8:0] puCount_r;
  logic [2:0] trkTicks_r;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      puCount_r <= '0;
      trkTicks_r <= '0;
    end else if (ce) begin
      puCount_r <= (state_r == ST_POWERUP) ? puCount_r + 1'b1 : '0;
      trkTicks_r <= (state_r != ST_TRACK) ? '0 : trkTicks_r + 3'(sarTick);
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  power_off_a: assert property (!enable_r && !burst_r |-> !convPowerOn)
    else $error("converter powered while disabled");
  burst_sleep_a: assert property (doneSet && needPowerup && !wrCtl |=> !convPowerOn)
    else $error("burst idle without power-down");
  done_busy_a: assert property (capture && lastConv |=> done_r && !busy)
    else $error("done flag and busy out of step");
  soft_start_a: assert property (!busy && enable_r && softStart && !hwStart && ce
    |=> busy)
    else $error("software start not taken");
  window_hit_a: assert property (winSet |=> win_r)
    else $error("window flag not set");
  pin_start_a: assert property (ce && !busy && enable_r && srcSel_r[SRC_PIN_BIT]
    && pinRise && !wrCtl |=> busy ##0 $past(extStartPin, 1) && !$past(pinPrev_r, 1))
    else $error("pin edge not taken");
  unsel_ignore_a: assert property (ce && !busy && srcSel_r == SRC_TMR2 && !timer2Ovf
    && !wrCtl |=> !busy)
    else $error("unselected trigger started conversion");
  track_three_a: assert property (state_r == ST_TRACK && state_nxt == ST_CONVERT && ce
    |-> trkTicks_r == 3'(DELAY_TRACK_SARCLK - 1))
    else $error("delayed tracking length wrong");
  powerup_len_a: assert property (state_r == ST_POWERUP && state_nxt != ST_POWERUP && ce
    |-> puCount_r + 9'h001 == $past(powerupCyc, 1))
    else $error("power-up delay length wrong");
  byte_low_a: assert property (capture && byteMode |=> resultLow == BYTE_MODE_LOW)
    else $error("low byte not zero in byte mode");
  gain_bit_a: assert property (wrCfg |=> inputGainOne == $past(sfrWrData[CFG_GAIN]))
    else $error("gain select not following register");

  single_cv: cover property (accept && !burst_r ##[1:300] doneSet);
  burst_cv: cover property (accept && needPowerup ##[1:1000] doneSet);
  window_cv: cover property (winSet && doneSet);
endmodule // sar_adc_ctrl

// >>> sar_adc_pkg.sv
// constants, field layout and state encoding for the converter control block
package sar_adc_pkg;
  // ***************************************************
  // register addresses and reset values
  // ***************************************************
  localparam logic [7:0] ADDR_CONFIG = 8'h97;
  localparam logic [7:0] ADDR_CONTROL = 8'hE8;
  localparam logic [7:0] CONFIG_RESET = 8'hF8;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // control register fields
  localparam int CTL_ENABLE = 7;
  localparam int CTL_BURST = 6;
  localparam int CTL_DONE = 5;
  localparam int CTL_BUSY = 4;
  localparam int CTL_WIN = 3;
  localparam int CTL_SRC_MSB = 2;
  localparam int CTL_SRC_LSB = 0;
  // config register fields
  localparam int CFG_DIV_MSB = 7;
  localparam int CFG_DIV_LSB = 3;
  localparam int CFG_BYTE = 2;
  localparam int CFG_TRACK = 1;
  localparam int CFG_GAIN = 0;
  // start source encodings
  localparam logic [2:0] SRC_SOFT = 3'h0;
  localparam logic [2:0] SRC_TMR0 = 3'h1;
  localparam logic [2:0] SRC_TMR2 = 3'h2;
  localparam logic [2:0] SRC_TMR3 = 3'h3;
  localparam int SRC_PIN_BIT = 2;
  // ***************************************************
  // timing
  // ***************************************************
  localparam int CLK_MHZ = 40;
  localparam int POWERUP_UNIT_NS = 400;
  localparam int POWERUP_UNIT_CYC = (POWERUP_UNIT_NS * CLK_MHZ + 999) / 1000;
  localparam int DELAY_TRACK_SARCLK = 3;
  localparam logic [1:0] BYTE_MODE_LSBS = 2'h0;
  localparam logic [7:0] BYTE_MODE_LOW = 8'h00;
  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_POWERUP = 2'b01,
    ST_TRACK = 2'b10,
    ST_CONVERT = 2'b11
  } seq_state_t;
endpackage

// >>> sar_clk_div.sv
// conversion clock divider producing one tick per (divider + 1) source ticks
`timescale 1ns/1ps
module sar_clk_div import sar_adc_pkg::*; #(
  parameter int DIV_W = 5
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // sequencer side
  sar_clk_if.div clkIf
);
  generate
    if (DIV_W < 1 || DIV_W > 8) begin : g_badWidth
      $error("sar_clk_div: DIV_W out of range");
    end
  endgenerate

  logic [DIV_W-1:0] cnt_r;
  logic [DIV_W:0] gap_r;
  logic seen_r;

  // ***************************************************
  // source selection and wrap
  // ***************************************************
  wire srcTick = clkIf.lpoSelect ? clkIf.lpoTick : 1'b1;
  wire wrap = srcTick && (cnt_r >= clkIf.divValue);
  assign clkIf.sarTick = clkIf.run && wrap;

  // counter of source ticks, held at zero while stopped
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (ce) begin
      if (!clkIf.run) cnt_r <= '0;
      else if (srcTick) cnt_r <= wrap ? '0 : cnt_r + 1'b1;
    end
  end

  // helper: source ticks between two sar ticks
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      gap_r <= '0;
      seen_r <= 1'b0;
    end else if (ce) begin
      if (!clkIf.run) begin
        gap_r <= '0;
        seen_r <= 1'b0;
      end else if (clkIf.sarTick) begin
        gap_r <= '0;
        seen_r <= 1'b1;
      end else if (srcTick) begin
        gap_r <= gap_r + 1'b1;
      end
    end
  end

  sar_period_a: assert property (@(posedge clk_sys) disable iff (rst)
    ce && clkIf.sarTick && seen_r && !clkIf.lpoSelect && $stable(clkIf.divValue)
    |-> gap_r == {1'b0, clkIf.divValue})
    else $error("sar tick spacing differs from divider plus one");
  lpo_source_a: assert property (@(posedge clk_sys) disable iff (rst)
    clkIf.lpoSelect && !clkIf.lpoTick |-> !clkIf.sarTick)
    else $error("sar tick without oscillator tick in burst");
endmodule // sar_clk_div

// >>> sar_clk_if.sv
// signals between the sequencer and the conversion clock divider
`timescale 1ns/1ps
interface sar_clk_if #(parameter int DIV_W = 5);
  logic [DIV_W-1:0] divValue;
  logic lpoSelect;
  logic lpoTick;
  logic run;
  logic sarTick;
  modport ctrl (output divValue, output lpoSelect, output lpoTick, output run, input sarTick);
  modport div (input divValue, input lpoSelect, input lpoTick, input run, output sarTick);
endinterface

// >>> tb.sv
// self-checking testbench for the converter control block
`timescale 1ns/1ps
module tb import sar_adc_pkg::*;;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [7:0] sfrAddr = 8'h00;
  logic [7:0] sfrWrData = 8'h00;
  logic sfrWrEn = 1'b0;
  logic sfrRdEn = 1'b0;
  logic [4:1] trig = 4'h0;
  logic lpoTick = 1'b0;
  logic [3:0] pwrField = 4'h1;
  logic [6:0] burstConvs = 7'h02;
  logic [15:0] winGt = 16'h0000;
  logic [15:0] winLt = 16'h03FF;
  logic [9:0] sample = 10'h000;
  logic [7:0] sfrRdData, resultHigh, resultLow, d;
  logic convPowerOn, inputGainOne, byteModeSel, tracking, sarTick, convStart;
  logic resultValid, doneIrq, windowIrq, prevDone;
  logic [9:0] resultData;
  logic [15:0] seed = 16'h3A29;
  logic [16:0] expq[$];
  int lpoCnt = 0;
  int n_mismatch = 0;
  int checked = 0;
  int trackTicks, gap, firstStart, nStarts;

  sar_adc_ctrl dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .sfrAddr(sfrAddr),
    .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData),
    .timer0Ovf(trig[1]), .timer2Ovf(trig[2]), .timer3Ovf(trig[3]), .extStartPin(trig[4]),
    .lpoTick(lpoTick), .powerupDelayField(pwrField), .burstConvs(burstConvs),
    .windowGreater(winGt), .windowLess(winLt), .convPowerOn(convPowerOn),
    .inputGainOne(inputGainOne), .byteModeSel(byteModeSel), .tracking(tracking),
    .sarTick(sarTick), .convStart(convStart), .resultValid(resultValid),
    .resultData(resultData), .resultHigh(resultHigh), .resultLow(resultLow),
    .doneIrq(doneIrq), .windowIrq(windowIrq));
  analog_model adc (.clk_sys(clk_sys), .rst(rst), .convStart(convStart), .sarTick(sarTick),
    .byteModeSel(byteModeSel), .sample(sample), .resultValid(resultValid),
    .resultData(resultData));

  always #12.5 clk_sys = ~clk_sys;
  // oscillator ticks, one every third cycle
  always @(negedge clk_sys) begin
    lpoCnt <= (lpoCnt == 2) ? 0 : lpoCnt + 1;
    lpoTick <= (lpoCnt == 0);
  end

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic chk(input string what, input logic [16:0] seen, input logic [16:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ***************************************************
  // bus cycles and triggers
  // ***************************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk_sys);
    sfrAddr = a;
    sfrWrData = v;
    sfrWrEn = 1'b1;
    @(negedge clk_sys);
    sfrWrEn = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk_sys);
    sfrAddr = a;
    sfrRdEn = 1'b1;
    @(negedge clk_sys);
    sfrRdEn = 1'b0;
    v = sfrRdData;
  endtask
  // one-cycle trigger; back-to-back calls leave pulses only two cycles apart
  task automatic pulse(input int k);
    @(negedge clk_sys);
    trig[k] = 1'b1;
    @(negedge clk_sys);
    trig[k] = 1'b0;
  endtask
  // waits for completion, measuring sar ticks, starts and busy
  task automatic wait_done();
    int n;
    int last;
    n = 0;
    last = 0;
    trackTicks = 0;
    nStarts = 0;
    firstStart = 0;
    while (doneIrq !== 1'b1) begin
      @(negedge clk_sys);
      n++;
      sfrRdEn = (n == 3);
      if (n == 3) begin
        sfrAddr = ADDR_CONTROL;
      end
      if (n == 4) begin
        chk("busy", sfrRdData[CTL_BUSY], 1'b1);
        chk("power", convPowerOn, 1'b1);
      end
      if (convStart === 1'b1) begin
        nStarts++;
        firstStart = (firstStart == 0) ? n : firstStart;
      end
      if (sarTick === 1'b1) begin
        gap = n - last;
        last = n;
        trackTicks += (tracking === 1'b1);
      end
      if (n > 3000) begin
        n_mismatch++;
        print_verdict();
      end
    end
  endtask
  // one conversion, or one burst, from the source in ctl, result noted for the watcher
  task automatic run(input logic [7:0] ctl, input logic [7:0] cfg);
    logic [9:0] r;
    logic [9:0] v;
    logic win;
    logic [7:0] c;
    seed = lfsr(seed);
    r = seed[9:0];
    sample = r;
    v = cfg[CFG_BYTE] ? {r[9:2], 2'h0} : r;
    win = (winGt < {6'h00, v}) && ({6'h00, v} < winLt);
    expq.push_back({win, cfg[CFG_BYTE] ? {r[9:2], 8'h00} : {6'h00, r}});
    wr(ADDR_CONFIG, cfg);
    wr(ADDR_CONTROL, ctl);
    if (ctl[2:0] == SRC_SOFT) begin
      wr(ADDR_CONTROL, ctl | 8'h10);
    end else begin
      pulse(ctl[2] ? 4 : int'(ctl[1:0]));
    end
    wait_done();
    rd(ADDR_CONTROL, c);
    chk("control", c, {ctl[7:6], 1'b1, 1'b0, win, ctl[2:0]});
    wr(ADDR_CONTROL, ctl);
  endtask
  // compares each completed result with the oldest note
  always @(negedge clk_sys) begin
    if (doneIrq === 1'b1 && prevDone !== 1'b1) begin
      chk("result", {windowIrq, resultHigh, resultLow}, expq.pop_front());
    end
    prevDone <= doneIrq;
  end
  // ***************************************************
  // main sequence
  // ***************************************************
  initial begin
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    rd(ADDR_CONFIG, d);
    chk("config reset", d, CONFIG_RESET);
    rd(ADDR_CONTROL, d);
    chk("control reset", d, CONTROL_RESET);
    wr(8'h55, 8'hFF);
    rd(8'h55, d);
    chk("unmapped", d, UNMAPPED_READ);
    wr(ADDR_CONTROL, 8'h10);
    repeat (40) @(negedge clk_sys);
    rd(ADDR_CONTROL, d);
    chk("disabled start", {d, convPowerOn, doneIrq}, 10'h000);
    run(8'h80, 8'h11);
    chk("divider", gap, 3);
    chk("gain one", inputGainOne, 1'b1);
    rd(ADDR_CONFIG, d);
    chk("config", d, 8'h11);
    // a write while the clock enable is low must be lost
    ce = 1'b0;
    wr(ADDR_CONFIG, 8'h00);
    ce = 1'b1;
    rd(ADDR_CONFIG, d);
    chk("frozen write", d, 8'h11);
    run(8'h80, 8'h16);
    chk("track ticks", trackTicks, DELAY_TRACK_SARCLK);
    chk("modes", {byteModeSel, inputGainOne}, 2'h2);
    for (int s = 1; s <= 4; s++) begin
      wr(ADDR_CONTROL, 8'h90 | 8'(s));
      for (int k = 1; k <= 4; k++) begin
        if (k != s) begin
          pulse(k);
        end
      end
      rd(ADDR_CONTROL, d);
      chk("ignored", {d, doneIrq}, {8'h80 | 8'(s), 1'b0});
      run(8'h80 | 8'(s), 8'h10);
    end
    winLt = 16'h0000;
    run(8'h40, 8'h10);
    chk("burst starts", nStarts, burstConvs);
    chk("burst divider", gap, 9);
    chk("powerup", firstStart, (pwrField + 1) * POWERUP_UNIT_CYC);
    chk("powered down", convPowerOn, 1'b0);
    chk("pending", expq.size(), 0);
    print_verdict();
  end
endmodule // tb
